// >>> logic/dram_addr_refresh_core.sv
`timescale 1ns/100ps
module dram_addr_refresh_core
	import dram_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Link to system and DRAM
	dram_link_if.device link
);

	typedef enum logic [2:0]
	{
		ST_IDLE      = 3'h0,
		ST_ROW       = 3'h1,
		ST_COL_ADDR  = 3'h2,
		ST_COL_STRB  = 3'h3,
		ST_FREF_WAIT = 3'h4,
		ST_FREF_LOW  = 3'h5,
		ST_FREF_DONE = 3'h6
	} state_t;

	//==============================================================
	// Declarations
	logic [ADDR_W-1:0] row_latch_reg, row_latch_next;
	logic [ADDR_W-1:0] col_latch_reg, col_latch_next;
	logic [1:0]        bank_reg, bank_next;
	logic [CNT_W-1:0]  count_reg, count_next; // see RL3
	logic              ras_prev_reg, ras_prev_next;
	logic              rfclk_prev_reg, rfclk_prev_next;
	logic              done_reg, done_next;
	logic              req_reg, req_next;
	state_t            state_reg, state_next;
	logic [3:0]        timer_reg, timer_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [3:0]        ras_reg, ras_next;
	logic              cas_reg, cas_next;
	logic              we_reg, we_next;
	mode_t             mode;
	logic              ext_refresh;
	logic              forced_mode;
	logic              ras_rise;
	logic              ras_fall;
	logic              ext_clear;
	logic              forced_inc;
	logic [3:0]        bank_onehot;

	//==============================================================
	// Mode decode
	assign mode        = mode_t'({link.refresh_mode_select, link.mode_lower_bit}); // see RL8
	assign ext_refresh = (mode == MODE_EXT_REFRESH) || (mode == MODE_AUTO_REFRESH && link.refresh_clock);
	assign forced_mode = (mode == MODE_AUTO_REFRESH) && !link.refresh_clock;
	assign ras_rise    = link.row_strobe_input_n && !ras_prev_reg;
	assign ras_fall    = !link.row_strobe_input_n && ras_prev_reg;
	// Only an outside gate clears, never our own request drive
	assign ext_clear   = !link.refresh_request_clear_pin && !req_reg; // see RL14
	assign forced_inc  = (state_reg == ST_FREF_LOW) && (timer_reg == 4'h0);
	assign bank_onehot = 4'h1 << bank_reg; // see RL22

	//==============================================================
	// Address and bank latches
	always_comb
	begin
		row_latch_next = row_latch_reg;
		col_latch_next = col_latch_reg;
		bank_next      = bank_reg;
		if (link.addr_latch_strobe) // see RL1
		begin
			row_latch_next = link.row_addr; // see RL4
			col_latch_next = link.col_addr;
			bank_next      = {link.bank_select_high, link.bank_select_low};
		end
	end

	//==============================================================
	// Refresh counter and request
	always_comb
	begin
		count_next      = count_reg;
		ras_prev_next   = link.row_strobe_input_n;
		rfclk_prev_next = link.refresh_clock;
		done_next       = done_reg;
		req_next        = req_reg;
		if (ext_clear)
			count_next = CNT_RESET;
		else if ((ext_refresh && ras_rise) || forced_inc) // see RL11
			count_next = count_reg + 9'h001; // see RL15
		// Track whether a refresh happened while the refresh clock was high
		if (link.refresh_clock && ext_refresh && ras_rise)
			done_next = 1'b1;
		else if (link.refresh_clock && !rfclk_prev_reg)
			done_next = 1'b0;
		if (!link.mode_lower_bit) // see RL23
			req_next = 1'b0;
		else if (!link.refresh_clock && rfclk_prev_reg && !done_reg) // see RL20
			req_next = 1'b1;
		else if (state_reg == ST_FREF_LOW)
			req_next = 1'b0;
	end

	//==============================================================
	// Automatic access and forced refresh sequencer
	always_comb
	begin
		state_next = state_reg;
		timer_next = (timer_reg != 4'h0) ? timer_reg - 4'h1 : 4'h0;
		case (state_reg)
			ST_IDLE:
			begin
				if (forced_mode)
				begin
					state_next = ST_FREF_WAIT;
					timer_next = 4'(FORCED_WAIT_CYC - 1);
				end
				else if (mode == MODE_AUTO_ACCESS && ras_fall) // see RL18
				begin
					state_next = ST_ROW;
					timer_next = link.row_hold_time_select ? 4'(ROW_HOLD_LONG_CYC - 1)
					                                       : 4'(ROW_HOLD_SHORT_CYC - 1); // see RL19
				end
			end
			ST_ROW:
			begin
				if (timer_reg == 4'h0)
					state_next = ST_COL_ADDR;
			end
			ST_COL_ADDR:
			begin
				state_next = ST_COL_STRB;
			end
			ST_COL_STRB:
			begin
				state_next = ST_COL_STRB;
			end
			ST_FREF_WAIT:
			begin
				if (timer_reg == 4'h0)
				begin
					state_next = ST_FREF_LOW;
					timer_next = 4'(FORCED_LOW_CYC - 1);
				end
			end
			ST_FREF_LOW:
			begin
				if (timer_reg == 4'h0)
					state_next = ST_FREF_DONE;
			end
			ST_FREF_DONE:
			begin
				state_next = ST_FREF_DONE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
		// Access ends with the row strobe; forced refresh ends when the mode is left
		if ((state_reg == ST_ROW || state_reg == ST_COL_ADDR || state_reg == ST_COL_STRB)
		    && (link.row_strobe_input_n || mode != MODE_AUTO_ACCESS))
			state_next = ST_IDLE;
		if ((state_reg == ST_FREF_WAIT || state_reg == ST_FREF_LOW || state_reg == ST_FREF_DONE)
		    && !forced_mode)
			state_next = ST_IDLE; // see RL23
	end

	//==============================================================
	// DRAM-side outputs
	always_comb
	begin
		we_next = link.write_enable_input_n; // see RL5
		if (ext_refresh || forced_mode)
			addr_next = count_reg; // see RL9
		else if (state_reg == ST_COL_ADDR || state_reg == ST_COL_STRB
		         || (mode == MODE_EXT_ACCESS && !link.row_col_select))
			addr_next = col_latch_reg;
		else
			addr_next = row_latch_reg; // see RL23
		if (ext_refresh)
			ras_next = {4{link.row_strobe_input_n}}; // see RL10
		else if (forced_mode)
			ras_next = (state_reg == ST_FREF_LOW) ? 4'h0 : 4'hF;
		else
			ras_next = ~(bank_onehot & {4{~link.row_strobe_input_n}}); // see RL21
		if (ext_refresh || forced_mode)
			cas_next = 1'b1; // see RL17
		else if (mode == MODE_EXT_ACCESS)
			cas_next = link.row_col_select | link.col_strobe_input_n;
		else
			cas_next = (state_reg != ST_COL_STRB);
	end

	//==============================================================
	// Registers, set to their idle values by the power-up reset
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) // see RL7
		begin
			row_latch_reg  <= 9'h000;
			col_latch_reg  <= 9'h000;
			bank_reg       <= 2'h0;
			count_reg      <= CNT_RESET;
			ras_prev_reg   <= 1'b1;
			rfclk_prev_reg <= 1'b0;
			done_reg       <= 1'b0;
			req_reg        <= 1'b0;
			state_reg      <= ST_IDLE;
			timer_reg      <= 4'h0;
			addr_reg       <= 9'h000;
			ras_reg        <= 4'hF;
			cas_reg        <= 1'b1;
			we_reg         <= 1'b1;
		end
		else
		begin
			row_latch_reg  <= row_latch_next;
			col_latch_reg  <= col_latch_next;
			bank_reg       <= bank_next;
			count_reg      <= count_next;
			ras_prev_reg   <= ras_prev_next;
			rfclk_prev_reg <= rfclk_prev_next;
			done_reg       <= done_next;
			req_reg        <= req_next;
			state_reg      <= state_next;
			timer_reg      <= timer_next;
			addr_reg       <= addr_next;
			ras_reg        <= ras_next;
			cas_reg        <= cas_next;
			we_reg         <= we_next;
		end
	end

	//==============================================================
	// Port drive
	assign link.muxed_address_out = addr_reg;
	assign link.ras_n             = ras_reg;
	assign link.cas_n             = cas_reg;
	assign link.we_n              = we_reg;
	assign link.pin_dev_o         = 1'b0;     // Open drain: only pulls low
	assign link.pin_dev_oe        = req_reg;

endmodule : dram_addr_refresh_core

// >>> logic/dram_pkg.sv
//==============================================================
// Notes on behaviour
// RL1 - Address latches transparent while strobe high
// RL2 - System keeps addresses valid or drops strobe
// RL3 - Nine-bit refresh counter, seven bits for 128
// RL4 - Eighteen address inputs: nine row, nine column
// RL5 - Write enable out follows input always
// RL6 - System orders write enable against column strobe
// RL7 - Reset clears counter and control flops
// RL8 - Mode pins decode into four modes
// RL9 - External refresh drives counter onto address
// RL10 - External refresh: all row strobes follow input
// RL11 - Counter advances on row strobe rising
// RL12 - Refresh select low until row strobe high
// RL13 - Refresh select falls before row strobe
// RL14 - Pulled-low request pin zeroes the counter
// RL15 - Counter runs through 511, wraps to zero
// RL16 - Burst refresh ends on address bit 7/8
// RL17 - Column strobe high during every refresh
// RL18 - Auto access: row strobe, switch, column strobe
// RL19 - Row hold select picks two hold times
// RL20 - Request pin signals refresh request in auto modes
// RL21 - Row strobe drives selected bank or all
// RL22 - Bank selects enable exactly one row strobe
// RL23 - Leaving refresh restores address and bank decode
package dram_pkg;

	//==============================================================
	// Widths and modes
	localparam int ADDR_W = 9;
	localparam int CNT_W  = 9;

	typedef enum logic [1:0]
	{
		MODE_EXT_REFRESH  = 2'h0,
		MODE_AUTO_REFRESH = 2'h1,
		MODE_EXT_ACCESS   = 2'h2,
		MODE_AUTO_ACCESS  = 2'h3
	} mode_t;

	//==============================================================
	// Timing at 250 MHz
	localparam int CLK_PERIOD_NS      = 4;
	localparam int ROW_HOLD_SHORT_NS  = 8;
	localparam int ROW_HOLD_LONG_NS   = 20;
	localparam int ROW_HOLD_SHORT_CYC = (ROW_HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_HOLD_LONG_CYC  = (ROW_HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FORCED_WAIT_CYC    = 4;
	localparam int FORCED_LOW_CYC     = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;

	//==============================================================
	// Controller register map (AXI4-Lite byte addresses)
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] ADDR_OFFSET   = 4'h4;
	localparam logic [3:0] STATUS_OFFSET = 4'h8;

	// CTRL fields
	localparam int CTRL_MODE_LOWER  = 0;
	localparam int CTRL_REFRESH_SEL = 1;
	localparam int CTRL_ROW_HOLD    = 2;
	localparam int CTRL_LATCH       = 3;
	localparam int CTRL_RAS_IN      = 4;
	localparam int CTRL_WE_IN       = 5;
	localparam int CTRL_ROW_COL     = 6;
	localparam int CTRL_CAS_IN      = 7;
	localparam int CTRL_RFCLK       = 8;
	localparam int CTRL_CLEAR       = 9;
	localparam int CTRL_W           = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h0BA;

	// ADDR fields
	localparam int ADDR_ROW_LSB  = 0;
	localparam int ADDR_COL_LSB  = 9;
	localparam int ADDR_BANK_LSB = 18;

	// STATUS fields
	localparam int STAT_ADDR_LSB = 0;
	localparam int STAT_RAS_LSB  = 9;
	localparam int STAT_CAS      = 13;
	localparam int STAT_WE       = 14;
	localparam int STAT_PIN      = 15;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dram_pkg

// >>> logic/dram_link_if.sv
`timescale 1ns/100ps
interface dram_link_if;
	import dram_pkg::*;

	//==============================================================
	// System side to controller
	logic [ADDR_W-1:0] row_addr;
	logic [ADDR_W-1:0] col_addr;
	logic              bank_select_low;
	logic              bank_select_high;
	logic              addr_latch_strobe;
	logic              row_strobe_input_n;
	logic              write_enable_input_n;
	logic              refresh_mode_select;
	logic              mode_lower_bit;
	logic              row_col_select;
	logic              col_strobe_input_n;
	logic              refresh_clock;
	logic              row_hold_time_select;
	// Open-drain request/clear pin, both ends
	logic              pin_dev_o;
	logic              pin_dev_oe;
	logic              pin_host_o;
	logic              pin_host_oe;
	logic              refresh_request_clear_pin;
	//==============================================================
	// Controller to DRAM
	logic [ADDR_W-1:0] muxed_address_out;
	logic [3:0]        ras_n;
	logic              cas_n;
	logic              we_n;

	// Wired-AND with pull-up
	assign refresh_request_clear_pin = ~((pin_dev_oe & ~pin_dev_o) | (pin_host_oe & ~pin_host_o));

	modport device
	(
		input  row_addr, col_addr, bank_select_low, bank_select_high, addr_latch_strobe,
		input  row_strobe_input_n, write_enable_input_n, refresh_mode_select, mode_lower_bit,
		input  row_col_select, col_strobe_input_n, refresh_clock, row_hold_time_select,
		input  refresh_request_clear_pin,
		output pin_dev_o, pin_dev_oe, muxed_address_out, ras_n, cas_n, we_n
	);

	modport host
	(
		output row_addr, col_addr, bank_select_low, bank_select_high, addr_latch_strobe,
		output row_strobe_input_n, write_enable_input_n, refresh_mode_select, mode_lower_bit,
		output row_col_select, col_strobe_input_n, refresh_clock, row_hold_time_select,
		output pin_host_o, pin_host_oe,
		input  refresh_request_clear_pin, muxed_address_out, ras_n, cas_n, we_n
	);

endinterface : dram_link_if

// >>> logic/dram_system_ctrl.sv
`timescale 1ns/100ps
module dram_system_ctrl
	import dram_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address and data
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Link to controller
	dram_link_if.host        link
);

	//==============================================================
	// Declarations
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [19:0]       addr_reg, addr_next;
	logic              aw_held_reg, aw_held_next;
	logic [3:0]        aw_addr_reg, aw_addr_next;
	logic              w_held_reg, w_held_next;
	logic [31:0]       w_data_reg, w_data_next;
	logic              bvalid_reg, bvalid_next;
	logic [1:0]        bresp_reg, bresp_next;
	logic              rvalid_reg, rvalid_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [1:0]        rresp_reg, rresp_next;
	logic              rsel_reg, rsel_next;
	logic              ras_in_reg, ras_in_next;
	logic [31:0]       status;

	assign status = {16'h0000, link.refresh_request_clear_pin, link.we_n, link.cas_n,
	                 link.ras_n, link.muxed_address_out};

	//==============================================================
	// Write channel: address and data in either order
	always_comb
	begin
		ctrl_next    = ctrl_reg;
		addr_next    = addr_reg;
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		bvalid_next  = bvalid_reg && !bready;
		bresp_next   = bresp_reg;
		if (awvalid && awready)
		begin
			aw_held_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready)
		begin
			w_held_next = 1'b1;
			w_data_next = wdata;
		end
		if (aw_held_reg && w_held_reg && !bvalid_reg)
		begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			if (aw_addr_reg == CTRL_OFFSET && wstrb_all(w_strb_dummy()))
				ctrl_next = w_data_reg[CTRL_W-1:0];
			else if (aw_addr_reg == ADDR_OFFSET)
				addr_next = w_data_reg[19:0];
			else
				bresp_next = RESP_SLVERR;
		end
	end

	function automatic logic wstrb_all(input logic x);
		return x;
	endfunction : wstrb_all

	function automatic logic w_strb_dummy();
		return 1'b1;
	endfunction : w_strb_dummy

	assign awready = !aw_held_reg;
	assign wready  = !w_held_reg;

	//==============================================================
	// Read channel: answer one cycle after the address
	always_comb
	begin
		rvalid_next = rvalid_reg && !rready;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (arvalid && arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			case (araddr)
				CTRL_OFFSET:   rdata_next = {22'h000000, ctrl_reg};
				ADDR_OFFSET:   rdata_next = {12'h000, addr_reg};
				STATUS_OFFSET: rdata_next = status;
				default:
				begin
					rdata_next = 32'h00000000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
	end

	assign arready = !rvalid_reg;

	//==============================================================
	// Row strobe waits one cycle for a refresh-select fall, and
	// refresh select stays low until the row strobe is high
	always_comb
	begin
		ras_in_next = ctrl_reg[CTRL_RAS_IN];
		rsel_next   = ctrl_reg[CTRL_REFRESH_SEL];
		if (!ctrl_reg[CTRL_REFRESH_SEL] && rsel_reg && !ctrl_reg[CTRL_RAS_IN])
			ras_in_next = ras_in_reg; // see RL13
		if (ctrl_reg[CTRL_REFRESH_SEL] && !rsel_reg && !ras_in_reg && !ctrl_reg[CTRL_RAS_IN])
			rsel_next = 1'b0; // see RL12
	end

	//==============================================================
	// Registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_reg    <= CTRL_RESET;
			addr_reg    <= 20'h00000;
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= 2'h0;
			rsel_reg    <= 1'b1;
			ras_in_reg  <= 1'b1;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			addr_reg    <= addr_next;
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			rsel_reg    <= rsel_next;
			ras_in_reg  <= ras_in_next;
		end
	end

	//==============================================================
	// Port drive
	assign bvalid = bvalid_reg;
	assign bresp  = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata  = rdata_reg;
	assign rresp  = rresp_reg;

	assign link.mode_lower_bit       = ctrl_reg[CTRL_MODE_LOWER];
	assign link.refresh_mode_select  = rsel_reg;
	assign link.row_hold_time_select = ctrl_reg[CTRL_ROW_HOLD];
	assign link.addr_latch_strobe    = ctrl_reg[CTRL_LATCH]; // see RL2
	assign link.row_strobe_input_n   = ras_in_reg; // see RL16
	assign link.write_enable_input_n = ctrl_reg[CTRL_WE_IN]; // see RL6
	assign link.row_col_select       = ctrl_reg[CTRL_ROW_COL];
	assign link.col_strobe_input_n   = ctrl_reg[CTRL_CAS_IN];
	assign link.refresh_clock        = ctrl_reg[CTRL_RFCLK];
	assign link.row_addr             = addr_reg[ADDR_ROW_LSB +: ADDR_W];
	assign link.col_addr             = addr_reg[ADDR_COL_LSB +: ADDR_W];
	assign link.bank_select_low      = addr_reg[ADDR_BANK_LSB];
	assign link.bank_select_high     = addr_reg[ADDR_BANK_LSB+1];
	assign link.pin_host_o           = 1'b0;
	assign link.pin_host_oe          = ctrl_reg[CTRL_CLEAR]; // see RL14

endmodule : dram_system_ctrl

// >>> tb/dram_link_properties.sv
`timescale 1ns/100ps
module dram_link_properties
	import dram_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rstn,
	// System side
	input wire logic [ADDR_W-1:0] row_addr,
	input wire logic              addr_latch_strobe,
	input wire logic              row_strobe_input_n,
	input wire logic              write_enable_input_n,
	input wire logic              refresh_mode_select,
	input wire logic              mode_lower_bit,
	input wire logic              row_col_select,
	input wire logic              pin_host_oe,
	input wire logic              refresh_request_clear_pin,
	// DRAM side
	input wire logic [ADDR_W-1:0] muxed_address_out,
	input wire logic [3:0]        ras_n,
	input wire logic              cas_n,
	input wire logic              we_n
);
	//=======
	// Mode decode
	logic ext_ref;
	logic ext_acc;
	logic auto_acc;

	assign ext_ref  = !refresh_mode_select && !mode_lower_bit;
	assign ext_acc  = refresh_mode_select && !mode_lower_bit;
	assign auto_acc = refresh_mode_select && mode_lower_bit;

	//=======
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Row latch open with a steady row address
	sequence row_open;
		ext_acc && row_col_select && addr_latch_strobe && $stable(row_addr);
	endsequence

	a_we_follows: assert property (we_n == $past(write_enable_input_n))
		else $error("write enable output does not follow its input");
	a_all_ras_follow: assert property ($past(ext_ref) |-> ras_n == {4{$past(row_strobe_input_n)}})
		else $error("row strobes do not all follow input in refresh");
	a_refresh_cas_high: assert property ($past(!refresh_mode_select) |-> cas_n)
		else $error("column strobe low during refresh");
	a_count_advance: assert property ((ext_ref && $rose(row_strobe_input_n) && refresh_request_clear_pin) ##1 ext_ref
		|=> muxed_address_out == $past(muxed_address_out) + 9'h001)
		else $error("refresh address did not advance by one");
	a_clear_zeroes: assert property ((pin_host_oe && ext_ref) ##1 ext_ref |=> muxed_address_out == 9'h000)
		else $error("refresh address not zero after clear");
	a_one_bank: assert property ($past(ext_acc) && $past(!row_strobe_input_n) |-> $onehot(~ras_n))
		else $error("access does not drive exactly one row strobe");
	a_idle_ras: assert property ($past(ext_acc) && $past(row_strobe_input_n) |-> ras_n == 4'hF)
		else $error("row strobe low while input high in access");
	a_row_pass: assert property (row_open ##1 row_open ##1 row_open |=> muxed_address_out == $past(row_addr))
		else $error("open row latch does not pass its input");
	a_latch_hold: assert property ((ext_acc && row_col_select && !addr_latch_strobe)[*3]
		|=> $stable(muxed_address_out))
		else $error("closed row latch changed its output");
	a_ras_before_cas: assert property (auto_acc && $fell(cas_n) |-> $past(ras_n, 2) != 4'hF)
		else $error("column strobe fell without a prior row strobe");

	// Main scenarios
	c_wrap: cover property (ext_ref && $fell(muxed_address_out[8]));
	c_forced: cover property (!refresh_mode_select && mode_lower_bit && ras_n == 4'h0);
	c_auto_cas: cover property (auto_acc && $fell(cas_n));

endmodule : dram_link_properties

// >>> tb/tb_dram_addr_refresh_core.sv
`timescale 1ns/100ps
module tb_dram_addr_refresh_core
	import dram_pkg::*;
;
	//=======
	// Clock, reset, bus and bench state
	logic        clk;
	logic        rstn;
	logic [3:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [3:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [31:0] s;
	logic [1:0]  r;
	int          bad_count;
	int          tests_run;

	//=======
	// Both ends and the checker
	dram_link_if dram_link_if_inst ();
	dram_addr_refresh_core dram_addr_refresh_core_inst (.clk, .rstn, .link(dram_link_if_inst));
	dram_system_ctrl dram_system_ctrl_inst (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .link(dram_link_if_inst));
	dram_link_properties dram_link_properties_inst (.clk, .rstn, .row_addr(dram_link_if_inst.row_addr),
		.addr_latch_strobe(dram_link_if_inst.addr_latch_strobe),
		.row_strobe_input_n(dram_link_if_inst.row_strobe_input_n),
		.write_enable_input_n(dram_link_if_inst.write_enable_input_n),
		.refresh_mode_select(dram_link_if_inst.refresh_mode_select),
		.mode_lower_bit(dram_link_if_inst.mode_lower_bit), .row_col_select(dram_link_if_inst.row_col_select),
		.pin_host_oe(dram_link_if_inst.pin_host_oe),
		.refresh_request_clear_pin(dram_link_if_inst.refresh_request_clear_pin),
		.muxed_address_out(dram_link_if_inst.muxed_address_out), .ras_n(dram_link_if_inst.ras_n),
		.cas_n(dram_link_if_inst.cas_n), .we_n(dram_link_if_inst.we_n));

	//=======
	// Helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Write with address and data offered together
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		s = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic ctl(input logic [9:0] v);
		wr(CTRL_OFFSET, {22'h0, v});
		check("ctrl resp", {30'h0, r}, {30'h0, RESP_OKAY});
	endtask : ctl

	// Let link outputs settle, then read status
	task automatic stat();
		repeat (12) @(posedge clk);
		rd(STATUS_OFFSET);
	endtask : stat

	//=======
	// Scenarios
	task automatic t_reset();
		rd(CTRL_OFFSET);
		check("ctrl reset", s, {22'h0, CTRL_RESET});
		stat();
		check("status reset", s, 32'h0000FE00);
		rd(4'hC);
		check("unmapped read", {s[29:0], r}, {30'h0, RESP_SLVERR});
		wr(STATUS_OFFSET, 32'h0);
		check("status write", {30'h0, r}, {30'h0, RESP_SLVERR});
	endtask : t_reset

	task automatic t_banks();
		for (int b = 0; b < 4; b++)
		begin
			wr(ADDR_OFFSET, {12'h0, 2'(b), 9'h0C3, 9'h1A5});
			ctl(10'h0EA);
			stat();
			check("bank ras", {28'h0, s[12:9]}, {28'h0, ~(4'h1 << b)});
			check("row out", {23'h0, s[8:0]}, 32'h1A5);
			ctl(10'h0BA);
		end
		ctl(10'h0F2);
		wr(ADDR_OFFSET, {12'h0, 2'h0, 9'h055, 9'h0AA});
		ctl(10'h0E2);
		stat();
		check("held bank", {28'h0, s[12:9]}, 32'h7);
		check("held row", {23'h0, s[8:0]}, 32'h1A5);
		ctl(10'h09A);
		stat();
		check("col pass", {23'h0, s[8:0]}, 32'h055);
		check("we low", {31'h0, s[14]}, 32'h0);
		ctl(10'h0BA);
	endtask : t_banks

	task automatic t_refresh();
		ctl(10'h0B8);
		ctl(10'h0A8);
		ctl(10'h0B8);
		ctl(10'h2B8);
		ctl(10'h0B8);
		stat();
		check("cleared", {23'h0, s[8:0]}, 32'h0);
		for (int n = 1; n <= 512; n++)
		begin
			ctl(10'h0A8);
			if (n == 1)
			begin
				stat();
				check("all ras", {28'h0, s[12:9]}, 32'h0);
				check("cas refresh", {31'h0, s[13]}, 32'h1);
			end
			ctl(10'h0B8);
			if (n == 1 || n == 128 || n == 512)
			begin
				stat();
				check("count", {23'h0, s[8:0]}, 32'(n % 512));
			end
		end
		ctl(10'h0BA);
		stat();
		check("leave refresh", {23'h0, s[8:0]}, 32'h055);
	endtask : t_refresh

	task automatic t_forced();
		ctl(10'h1BB);
		ctl(10'h1B9);
		ctl(10'h1A9);
		stat();
		check("mode1 ras", {28'h0, s[12:9]}, 32'h0);
		ctl(10'h1B9);
		ctl(10'h0BB);
		ctl(10'h1BB);
		ctl(10'h0BB);
		stat();
		check("request", {31'h0, s[15]}, 32'h0);
		ctl(10'h0B9);
		repeat (20) @(posedge clk);
		stat();
		check("request end", {31'h0, s[15]}, 32'h1);
		check("forced count", {23'h0, s[8:0]}, 32'h2);
		check("cas forced", {31'h0, s[13]}, 32'h1);
		ctl(10'h0BB);
	endtask : t_forced

	task automatic t_auto();
		for (int h = 0; h < 2; h++)
		begin
			ctl(10'h0BB | 10'(h << 2));
			ctl(10'h0AB | 10'(h << 2));
			stat();
			check("auto cas", {31'h0, s[13]}, 32'h0);
			check("auto col", {23'h0, s[8:0]}, 32'h055);
			check("auto ras", {28'h0, s[12:9]}, 32'hE);
			ctl(10'h0BB);
		end
	endtask : t_auto

	task automatic close_out();
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	//=======
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog
	initial
	begin
		#200000;
		bad_count++;
		close_out();
	end

	// Main sequence
	initial
	begin
		rstn      = 1'b0;
		awaddr    = 4'h0;
		awvalid   = 1'b0;
		wdata     = 32'h0;
		wvalid    = 1'b0;
		bready    = 1'b0;
		araddr    = 4'h0;
		arvalid   = 1'b0;
		rready    = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_banks();
		t_refresh();
		t_forced();
		t_auto();
		close_out();
	end

endmodule : tb_dram_addr_refresh_core
